/* bench/tb_trolley_two_speed_travel_control.sv */
// Purpose: Self-checking bench for the two-speed trolley control.
// Assumes: Zero-wait APB; pin effects show within a few edges.
// Notes: Motor outputs are sampled on the falling edge, where they are settled.
module tb_trolley_two_speed_travel_control
    import trolley_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'h0;
    logic rstn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr, run, inv, byp, mot, dneg, lows;
    logic [2:0] stp, slw;
    logic signed [15:0] spd;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    always #2.5 mclk = ~mclk;
    trolley_travel i_trolley_travel (.i_mclk(mclk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_run(run), .i_setpoint_inversion_input(inv), .i_sensor_bypass_input(byp),
        .i_stop_sensor(stp), .i_slow_sensor(slw), .o_motor_on(mot), .o_dir_neg(dneg),
        .o_low_speed(lows), .o_speed_setpoint(spd));
    trolley_field i_trolley_field (.i_mclk(mclk), .o_run(run), .o_inv(inv), .o_byp(byp),
        .o_stop(stp), .o_slow(slw));
    // ********************************
    // Shared tasks
    // ********************************
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge mclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'h1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] q;
        logic e;
        apb(1'h0, a, 32'h0000_0000, q, e);
        chk("prdata", exp, q);
        chk("pslverr", {31'h0, err}, {31'h0, e});
    endtask
    task automatic wmot(input logic v);
        repeat (20) if (mot !== v) @(negedge mclk);
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    function automatic logic [31:0] cfg(input logic shut, input logic [2:0] ev);
        cfg = 32'h0000_0000;
        cfg[CFG_APP_LSB +: 8] = APP_TWO_SPEED;
        cfg[CFG_SHUT_BIT] = shut;
        cfg[CFG_STOP_LSB +: 3] = ev;
        cfg[CFG_SLOW_LSB +: 3] = EVAL_FALL;
        return cfg;
    endfunction
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_regs();
        rd(ADDR_CONFIG, 32'h0000_4500, 1'h0);
        rd(ADDR_SCALE, 32'h0000_0001, 1'h0);
        rd(8'h18, 32'h0000_0000, 1'h1);
        $display("test regs done");
    endtask
    task automatic t_run();
        i_trolley_field.start(1'h0);
        idle(10);
        chk("motor_on", 32'h0, mot);
        wr(ADDR_HIGH_SPEED, 32'h0000_0064);
        wr(ADDR_LOW_SPEED, 32'h0000_0014);
        wr(ADDR_SUPPL, 32'h0000_0005);
        wr(ADDR_SCALE, 32'h0000_0002);
        wr(ADDR_CONFIG, cfg(1'h1, EVAL_LOW));
        i_trolley_field.start(1'h0);
        wmot(1'h1);
        chk("motor_on", 32'h1, mot);
        chk("dir_neg", 32'h0, dneg);
        chk("speed", 32'h0000_00CD, {16'h0, spd});
        $display("test run done");
    endtask
    task automatic t_end();
        i_trolley_field.sense(3'h7, 3'h6, 1'h0);
        idle(8);
        chk("low_speed", 32'h1, lows);
        chk("speed", 32'h0000_002D, {16'h0, spd});
        i_trolley_field.sense(3'h6, 3'h7, 1'h0);
        wmot(1'h0);
        chk("motor_on", 32'h0, mot);
        i_trolley_field.sense(3'h7, 3'h7, 1'h0);
        idle(8);
        chk("motor_on", 32'h0, mot);
        rd(ADDR_STATUS, 32'h0000_0018, 1'h0);
        i_trolley_field.start(1'h0);
        idle(10);
        chk("motor_on", 32'h0, mot);
        i_trolley_field.start(1'h1);
        wmot(1'h1);
        chk("speed", 32'h0000_FF33, {16'h0, spd});
        chk("dir_neg", 32'h1, dneg);
        $display("test end stop done");
    endtask
    task automatic t_centre();
        i_trolley_field.sense(3'h3, 3'h7, 1'h0);
        wmot(1'h0);
        chk("motor_on", 32'h0, mot);
        i_trolley_field.sense(3'h7, 3'h7, 1'h0);
        wmot(1'h1);
        chk("motor_on", 32'h1, mot);
        i_trolley_field.sense(3'h3, 3'h3, 1'h1);
        idle(8);
        chk("motor_on", 32'h1, mot);
        i_trolley_field.sense(3'h7, 3'h7, 1'h0);
        $display("test centre done");
    endtask
    task automatic t_shut();
        wr(ADDR_CONFIG, cfg(1'h0, EVAL_LOW));
        i_trolley_field.start(1'h0);
        wmot(1'h1);
        i_trolley_field.sense(3'h6, 3'h7, 1'h0);
        idle(8);
        chk("motor_on", 32'h1, mot);
        // Rising-edge stop mode: releasing the held positive stop sensor is the event
        wr(ADDR_CONFIG, cfg(1'h1, EVAL_RISE));
        idle(4);
        chk("motor_on", 32'h1, mot);
        i_trolley_field.sense(3'h7, 3'h7, 1'h0);
        wmot(1'h0);
        chk("motor_on", 32'h0, mot);
        $display("test shutdown off done");
    endtask
    // A hang is cut short well beyond the few hundred cycles the tests need
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_mismatch++;
            summarize();
        end
    end
    initial
    begin
        repeat (12) @(posedge mclk);
        rstn <= 1'h1;
        t_regs();
        t_run();
        t_end();
        t_centre();
        t_shut();
        summarize();
    end
endmodule // tb_trolley_two_speed_travel_control

/* bench/trolley_field.sv */
// Purpose: Sensors on the track and the controlling PLC.
// Assumes: Sensors idle high, so low-level and falling-edge modes see no event.
// Notes: Pins change only just after a rising edge.
module trolley_field (
    // Clock
    input wire logic i_mclk,
    // Pins toward the trolley control
    output logic o_run,
    output logic o_inv,
    output logic o_byp,
    output logic [2:0] o_stop,
    output logic [2:0] o_slow
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        o_run = 1'h0;
        o_inv = 1'h0;
        o_byp = 1'h0;
        o_stop = 3'h7;
        o_slow = 3'h7;
    end
    // Run held low long enough to pass the synchroniser, so a rising edge is seen
    task automatic start(input logic neg);
        @(posedge i_mclk);
        o_run <= 1'h0;
        o_inv <= neg;
        repeat (4) @(posedge i_mclk);
        o_run <= 1'h1;
    endtask
    task automatic sense(input logic [2:0] stp, input logic [2:0] slw, input logic byp);
        @(posedge i_mclk);
        o_stop <= stp;
        o_slow <= slw;
        o_byp <= byp;
    endtask
endmodule // trolley_field

/* hw/trolley_travel.sv */
// Purpose: Two-speed travelling trolley control with APB configuration.
// Assumes: Sensor and command pins are asynchronous; APB is on i_mclk.
// Notes: Zero-wait APB slave; unmapped addresses answer with pslverr.
module trolley_travel
    import trolley_pkg::*;
(
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rstn,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Controller pins
    input wire logic i_run,
    input wire logic i_setpoint_inversion_input,
    input wire logic i_sensor_bypass_input,
    // Sensor pins, index 0 positive, 1 negative, 2 centre
    input wire logic [2:0] i_stop_sensor,
    input wire logic [2:0] i_slow_sensor,
    // Motor command
    output logic o_motor_on,
    output logic o_dir_neg,
    output logic o_low_speed,
    output logic signed [15:0] o_speed_setpoint
);
    state_type r;
    state_type n;
    logic [2:0] stop_t;
    logic [2:0] slow_t;
    logic run_edge;
    logic app_ok;
    logic ctr_stop;
    logic ctr_slow;
    logic end_stop;
    logic end_slow;
    logic stop_lvl;
    logic slow_lvl;
    logic hold;
    logic slow_hold;
    logic acc;
    logic mapped;
    logic signed [15:0] base;
    logic signed [31:0] full;

    // ********************************************
    // Sensor evaluation
    // ********************************************
    function automatic logic trig(input logic [2:0] t, input logic cur, input logic old);
        case (t)
            EVAL_HIGH: trig = cur;
            EVAL_LOW: trig = ~cur;
            EVAL_RISE: trig = cur & ~old;
            EVAL_FALL: trig = ~cur & old;
            default: trig = 1'b0;
        endcase
    endfunction

    for (genvar g = 0; g < 3; g++)
    begin : g_sens
        assign stop_t[g] = trig(r.stop_eval, r.s2[IN_STOP+g], r.prev[IN_STOP+g]);
        assign slow_t[g] = trig(r.slow_eval, r.s2[IN_SLOW+g], r.prev[IN_SLOW+g]);
    end

    assign run_edge = r.s2[IN_RUN] & ~r.prev[IN_RUN];
    assign app_ok = (r.app == APP_TWO_SPEED);
    assign stop_lvl = (r.stop_eval == EVAL_HIGH) || (r.stop_eval == EVAL_LOW);
    assign slow_lvl = (r.slow_eval == EVAL_HIGH) || (r.slow_eval == EVAL_LOW);
    assign ctr_stop = stop_t[2] & ~r.s2[IN_BYP];
    assign ctr_slow = slow_t[2] & ~r.s2[IN_BYP];
    assign end_stop = r.dir_neg ? stop_t[1] : stop_t[0];
    assign end_slow = r.dir_neg ? slow_t[1] : slow_t[0];
    // Level-mode centre sensors act only while held: stop pauses the run, slow lowers the speed; both end when released
    assign hold = r.shut_en & ctr_stop & stop_lvl;
    assign slow_hold = r.shut_en & ctr_slow & slow_lvl;

    // ********************************************
    // APB access
    // ********************************************
    assign acc = i_psel & i_penable;
    assign mapped = (i_paddr[1:0] == 2'h0) && (i_paddr <= ADDR_STATUS);
    assign o_pready = 1'b1;
    assign o_pslverr = acc & ~mapped;

    always_comb
    begin
        o_prdata = 32'h0000_0000;
        if (i_psel && !i_pwrite)
        begin
            case (i_paddr)
                ADDR_CONFIG: o_prdata = {17'h0_0000, r.slow_eval, r.stop_eval, r.shut_en, r.app};
                ADDR_HIGH_SPEED: o_prdata = {16'h0000, r.high_sp};
                ADDR_LOW_SPEED: o_prdata = {16'h0000, r.low_sp};
                ADDR_SUPPL: o_prdata = {16'h0000, r.suppl};
                ADDR_SCALE: o_prdata = {16'h0000, r.scale};
                ADDR_STATUS: o_prdata = {26'h000_0000, r.blk_dir, r.blocked, r.low_out, r.dir_neg,
                    r.moving, r.mot == MOT_RUN};
                default: o_prdata = 32'h0000_0000;
            endcase
        end
    end

    // ********************************************
    // Next state
    // ********************************************
    always_comb
    begin
        n = r;
        n.s1 = {i_slow_sensor, i_stop_sensor, i_sensor_bypass_input, i_setpoint_inversion_input, i_run};
        n.s2 = r.s1;
        n.prev = r.s2;
        if (acc && i_pwrite && mapped)
        begin
            case (i_paddr)
                ADDR_CONFIG:
                begin
                    n.app = i_pwdata[CFG_APP_LSB+:8];
                    n.shut_en = i_pwdata[CFG_SHUT_BIT];
                    n.stop_eval = i_pwdata[CFG_STOP_LSB+:3];
                    n.slow_eval = i_pwdata[CFG_SLOW_LSB+:3];
                end
                ADDR_HIGH_SPEED: n.high_sp = i_pwdata[15:0];
                ADDR_LOW_SPEED: n.low_sp = i_pwdata[15:0];
                ADDR_SUPPL: n.suppl = i_pwdata[15:0];
                ADDR_SCALE: n.scale = i_pwdata[15:0];
                default: n.app = r.app;
            endcase
        end
        unique case (r.mot)
            MOT_IDLE:
            begin
                // Only a fresh rising run command restarts travel
                if (run_edge && app_ok)
                begin
                    if (!(r.shut_en && r.blocked && (r.s2[IN_INV] == r.blk_dir)))
                    begin
                        n.mot = MOT_RUN;
                        n.dir_neg = r.s2[IN_INV];
                        n.slow = 1'b0;
                        n.blocked = 1'b0;
                    end
                end
            end
            MOT_RUN:
            begin
                if (!app_ok || !r.s2[IN_RUN])
                begin
                    n.mot = MOT_IDLE;
                end
                else if (r.shut_en)
                begin
                    if (end_stop)
                    begin
                        n.mot = MOT_IDLE;
                        n.blocked = 1'b1;
                        n.blk_dir = r.dir_neg;
                    end
                    else if (ctr_stop && !stop_lvl)
                    begin
                        n.mot = MOT_IDLE;
                    end
                    // End slow-downs latch so a released level keeps low speed
                    if (end_slow || (ctr_slow && !slow_lvl))
                    begin
                        n.slow = 1'b1;
                    end
                end
            end
        endcase
        // Registered motor command, derived from the state just computed
        n.moving = (n.mot == MOT_RUN) && !hold;
        n.low_out = n.slow | slow_hold;
    end

    // Speed: main setpoint times scale, plus supplementary on both speeds
    always_comb
    begin
        base = n.low_out ? r.low_sp : r.high_sp;
        full = base * r.scale + 32'(r.suppl);
    end

    // ********************************************
    // State register
    // ********************************************
    always_ff @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            r <= '{s1: '0, s2: '0, prev: '0, app: RST_APP, shut_en: RST_SHUT, stop_eval: RST_STOP_EVAL,
                slow_eval: RST_SLOW_EVAL, high_sp: RST_SETPOINT, low_sp: RST_SETPOINT, suppl: RST_SETPOINT,
                scale: RST_SCALE, mot: MOT_IDLE, dir_neg: 1'b0, slow: 1'b0, blocked: 1'b0, blk_dir: 1'b0,
                moving: 1'b0, low_out: 1'b0, speed: RST_SETPOINT};
        end
        else
        begin
            r <= n;
            r.speed <= !n.moving ? 16'sh0000 : (n.dir_neg ? -full[15:0] : full[15:0]);
        end
    end

    assign o_motor_on = r.moving;
    assign o_dir_neg = r.dir_neg;
    assign o_low_speed = r.low_out;
    assign o_speed_setpoint = r.speed;

    // ********************************************
    // Assertions
    // ********************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    sequence start_s;
        r.mot == MOT_IDLE && run_edge && app_ok;
    endsequence
    sequence pos_end_s;
        r.mot == MOT_RUN && r.s2[IN_RUN] && app_ok && r.shut_en && !r.dir_neg && stop_t[0];
    endsequence
    sequence neg_end_s;
        r.mot == MOT_RUN && r.s2[IN_RUN] && app_ok && r.shut_en && r.dir_neg && stop_t[1];
    endsequence

    app_gate_a: assert property (!app_ok |=> r.mot == MOT_IDLE)
        else $error("trolley ran outside application 12");
    start_high_a: assert property ($rose(r.mot == MOT_RUN) |-> !r.slow ##1 (r.moving || hold))
        else $error("run did not start at high speed");
    dir_pick_a: assert property ($rose(r.mot == MOT_RUN) |-> r.dir_neg == $past(r.s2[IN_INV]))
        else $error("direction not taken from inversion input");
    pos_stop_a: assert property (pos_end_s |=> r.mot == MOT_IDLE ##1 !o_motor_on)
        else $error("positive end stop ignored");
    neg_stop_a: assert property (neg_end_s |=> r.mot == MOT_IDLE && r.blk_dir)
        else $error("negative end stop ignored");
    fresh_run_a: assert property ($rose(r.mot == MOT_RUN) |-> $past(run_edge))
        else $error("restart without fresh run command");
    end_lock_a: assert property (start_s and (r.shut_en && r.blocked && r.s2[IN_INV] == r.blk_dir)
        |=> r.mot == MOT_IDLE)
        else $error("restart allowed toward the blocked end");
    bypass_a: assert property (r.s2[IN_BYP] |-> !ctr_stop && !ctr_slow && !hold)
        else $error("centre sensor acted under bypass");
    slow_keep_a: assert property (r.mot == MOT_RUN && r.slow && r.s2[IN_RUN] && app_ok |=> r.slow)
        else $error("latched low speed lost while running");
    free_dir_a: assert property (start_s and !r.shut_en |=> r.mot == MOT_RUN)
        else $error("start refused with shutdown disabled");
endmodule // trolley_travel

/* pkg/trolley_pkg.sv */
// Purpose: Shared constants and types for the two-speed trolley travel control.
// Assumes: APB slave with 32-bit data, one 200 MHz clock.
// Notes: Offsets are byte addresses; every register takes one aligned word.
package trolley_pkg;
    // ********************************************
    // Register map
    // ********************************************
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_HIGH_SPEED = 8'h04;
    localparam logic [7:0] ADDR_LOW_SPEED = 8'h08;
    localparam logic [7:0] ADDR_SUPPL = 8'h0C;
    localparam logic [7:0] ADDR_SCALE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // CONFIG fields
    localparam int CFG_APP_LSB = 0;
    localparam int CFG_SHUT_BIT = 8;
    localparam int CFG_STOP_LSB = 9;
    localparam int CFG_SLOW_LSB = 12;
    // ********************************************
    // Codes and reset values
    // ********************************************
    localparam logic [7:0] APP_TWO_SPEED = 8'h0C;
    localparam logic [2:0] EVAL_HIGH = 3'h1;
    localparam logic [2:0] EVAL_LOW = 3'h2;
    localparam logic [2:0] EVAL_RISE = 3'h3;
    localparam logic [2:0] EVAL_FALL = 3'h4;
    localparam logic [7:0] RST_APP = 8'h00;
    localparam logic RST_SHUT = 1'b1;
    localparam logic [2:0] RST_STOP_EVAL = EVAL_LOW;
    localparam logic [2:0] RST_SLOW_EVAL = EVAL_FALL;
    localparam logic [15:0] RST_SCALE = 16'h0001;
    localparam logic [15:0] RST_SETPOINT = 16'h0000;
    // Synchronised input vector positions
    localparam int IN_RUN = 0;
    localparam int IN_INV = 1;
    localparam int IN_BYP = 2;
    localparam int IN_STOP = 3;
    localparam int IN_SLOW = 6;
    localparam int IN_W = 9;

    typedef enum logic {MOT_IDLE, MOT_RUN} motion_type;

    typedef struct packed {
        logic [IN_W-1:0] s1;
        logic [IN_W-1:0] s2;
        logic [IN_W-1:0] prev;
        logic [7:0] app;
        logic shut_en;
        logic [2:0] stop_eval;
        logic [2:0] slow_eval;
        logic signed [15:0] high_sp;
        logic signed [15:0] low_sp;
        logic signed [15:0] suppl;
        logic signed [15:0] scale;
        motion_type mot;
        logic dir_neg;
        logic slow;
        logic blocked;
        logic blk_dir;
        logic moving;
        logic low_out;
        logic signed [15:0] speed;
    } state_type;
endpackage
